// ==== defect_map_pkg.sv ====
// package for the defect map translator: record byte offsets, signatures, types
// assumes one drive clock domain; no register bus
package defect_map_pkg;
   // ==========================================
   // record layout
   localparam int SECTOR_BYTES = 8192;
   localparam logic [15:0] SIG_HEAD = 16'ha5a5;
   localparam logic [15:0] SIG_TAIL = 16'h5a5a;
   localparam int OFS_SIG_HEAD = 0;
   localparam int OFS_SIG_TAIL = 8190;
   localparam int OFS_PL1_START = 35;
   localparam int OFS_PL1_END = 39;
   localparam int OFS_PL1_FLAG = 43;
   localparam int OFS_PL1_MAP = 44;
   localparam int OFS_SL_START = 60;
   localparam int OFS_SL_END = 64;
   localparam int OFS_SL_MAXENT = 68;
   localparam int OFS_PSA_START = 70;
   localparam int OFS_PSA_END = 74;
   localparam int OFS_SSA_START = 78;
   localparam int OFS_SSA_END = 82;
   localparam int OFS_COPY_START = 86;
   localparam int OFS_COPY_END = 90;
   localparam int OFS_PL2_START = 94;
   localparam int OFS_PL2_END = 98;
   localparam int OFS_PL2_FLAG = 102;
   localparam int OFS_PL2_MAP = 103;
   localparam int OFS_PL3_START = 119;
   localparam int OFS_PL3_END = 123;
   localparam int OFS_PL3_FLAG = 127;
   localparam int OFS_PL3_MAP = 128;
   localparam int OFS_DEFINED_END = 144;
   localparam logic [31:0] NO_PAGE_ADDR = 32'h7fffffff;
   localparam int MAP_BYTES = 16;

   typedef struct packed {
      logic [31:0] startAddr;
      logic [31:0] endAddr;
      logic valid;
      logic [127:0] goodMap;
   } list_copy_t;

   typedef struct packed {
      logic [31:0] slStart;
      logic [31:0] slEnd;
      logic [15:0] slMaxEntries;
      logic [31:0] psaStart;
      logic [31:0] psaEnd;
      logic [31:0] ssaStart;
      logic [31:0] ssaEnd;
      logic [31:0] copyStart;
      logic [31:0] copyEnd;
   } area_map_t;

   typedef struct packed {
      logic [31:0] physical_block_address;
      logic malformed;
      logic slipped;
      logic replaced;
   } xlate_result_t;

   typedef enum logic [1:0] {
      MEDIA_RW,
      MEDIA_WRITE_ONCE
   } media_t;
endpackage : defect_map_pkg

// ==== defect_map_translator.sv ====
// defect map translator: parses the disk definition record byte stream, checks it,
// and translates block addresses through slip and replacement tables.
// assumes the datapath streams a whole record sector, byte by byte, and fills the tables.
//
// Function
// - one sector, head and tail signatures checked
// - first primary copy addresses, flag, bitmap
// - secondary list bounds and per-page limit
// - primary and secondary spare bounds captured
// - copy area and second primary copy
// - third primary copy; trailing bytes ignored
// - vendor and revision fields disregarded
// - start field marks unwritten copy invalid
// - end field holds last good block
// - flag other than zero/one is malformed
// - bitmap set bit means good sector
// - slip and total relocation limits enforced
// - below area slip shifts toward area
// - above area slip shifts toward area
// - certification defects entered until table full or slip limit hit, empty allowed
// - late defect goes to first free spare
// - defective spare skipped to next available
// - entry position derives spare address
// - primary-listed address never entered secondary
// - failed spare gets its own new entry
// - write-once initialised once only
// - rewritable init leaves secondary areas erased
// - spare equals entry index plus first spare
// - entries ascend by replacement address
`timescale 1ns/1ps
module defect_map_translator #(
   parameter int SLIP_DEPTH = 16,
   parameter int REPL_DEPTH = 16,
   parameter int DMA_SECTORS = 1024
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // record byte stream
   input wire logic recValid,
   input wire logic [7:0] recByte,
   input wire logic recFirst,
   output logic recDone,
   output logic recGood,
   output defect_map_pkg::list_copy_t copy1,
   output defect_map_pkg::list_copy_t copy2,
   output defect_map_pkg::list_copy_t copy3,
   output defect_map_pkg::area_map_t areas,
   // media control
   input wire defect_map_pkg::media_t mediaType,
   input wire logic initReq,
   output logic initGrant,
   output logic initRefused,
   output logic eraseSecondary,
   input wire logic dmaStartValid,
   input wire logic [31:0] dmaStart,
   // primary list entry (certification defects, ascending)
   input wire logic primAdd,
   input wire logic [31:0] primAddr,
   // late defect report
   input wire logic lateAdd,
   input wire logic [31:0] lateAddr,
   input wire logic spareBad,
   output logic lateAccepted,
   output logic lateRejected,
   output logic [31:0] lateSpare,
   output logic [15:0] lateIndex,
   // translation
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [31:0] reqAddr,
   output logic rspValid,
   output defect_map_pkg::xlate_result_t rsp,
   output logic limitExceeded
);
   import defect_map_pkg::*;

   // ==========================================
   // record parse
   logic [12:0] idx_q;
   logic [15:0] headSig_q;
   logic [15:0] tailSig_q;
   logic [7:0] flag1_q, flag2_q, flag3_q;
   list_copy_t c1_q, c2_q, c3_q;
   area_map_t ar_q;
   logic done_q;
   logic [12:0] curIdx;
   assign curIdx = recFirst ? 13'h0000 : idx_q;

   function automatic logic [31:0] shiftIn32(input logic [31:0] v, input logic [7:0] b);
      shiftIn32 = {v[23:0], b};
   endfunction : shiftIn32

   function automatic logic inField(input logic [12:0] i, input int ofs, input int len);
      inField = (int'(i) >= ofs) && (int'(i) < ofs + len);
   endfunction : inField

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         idx_q <= 13'h0000;
         headSig_q <= 16'h0000;
         tailSig_q <= 16'h0000;
         flag1_q <= 8'h00;
         flag2_q <= 8'h00;
         flag3_q <= 8'h00;
         c1_q <= '0;
         c2_q <= '0;
         c3_q <= '0;
         ar_q <= '0;
         done_q <= 1'b0;
      end else if (recValid) begin
         idx_q <= curIdx + 13'h0001;
         done_q <= (int'(curIdx) == SECTOR_BYTES - 1);
         if (inField(curIdx, OFS_SIG_HEAD, 2)) headSig_q <= {headSig_q[7:0], recByte};
         if (inField(curIdx, OFS_SIG_TAIL, 2)) tailSig_q <= {tailSig_q[7:0], recByte};
         if (inField(curIdx, OFS_PL1_START, 4)) c1_q.startAddr <= shiftIn32(c1_q.startAddr, recByte);
         if (inField(curIdx, OFS_PL1_END, 4)) c1_q.endAddr <= shiftIn32(c1_q.endAddr, recByte);
         if (int'(curIdx) == OFS_PL1_FLAG) flag1_q <= recByte;
         if (inField(curIdx, OFS_PL1_MAP, MAP_BYTES)) c1_q.goodMap <= {c1_q.goodMap[119:0], recByte};
         if (inField(curIdx, OFS_SL_START, 4)) ar_q.slStart <= shiftIn32(ar_q.slStart, recByte);
         if (inField(curIdx, OFS_SL_END, 4)) ar_q.slEnd <= shiftIn32(ar_q.slEnd, recByte);
         if (inField(curIdx, OFS_SL_MAXENT, 2)) ar_q.slMaxEntries <= {ar_q.slMaxEntries[7:0], recByte};
         if (inField(curIdx, OFS_PSA_START, 4)) ar_q.psaStart <= shiftIn32(ar_q.psaStart, recByte);
         if (inField(curIdx, OFS_PSA_END, 4)) ar_q.psaEnd <= shiftIn32(ar_q.psaEnd, recByte);
         if (inField(curIdx, OFS_SSA_START, 4)) ar_q.ssaStart <= shiftIn32(ar_q.ssaStart, recByte);
         if (inField(curIdx, OFS_SSA_END, 4)) ar_q.ssaEnd <= shiftIn32(ar_q.ssaEnd, recByte);
         if (inField(curIdx, OFS_COPY_START, 4)) ar_q.copyStart <= shiftIn32(ar_q.copyStart, recByte);
         if (inField(curIdx, OFS_COPY_END, 4)) ar_q.copyEnd <= shiftIn32(ar_q.copyEnd, recByte);
         if (inField(curIdx, OFS_PL2_START, 4)) c2_q.startAddr <= shiftIn32(c2_q.startAddr, recByte);
         if (inField(curIdx, OFS_PL2_END, 4)) c2_q.endAddr <= shiftIn32(c2_q.endAddr, recByte);
         if (int'(curIdx) == OFS_PL2_FLAG) flag2_q <= recByte;
         if (inField(curIdx, OFS_PL2_MAP, MAP_BYTES)) c2_q.goodMap <= {c2_q.goodMap[119:0], recByte};
         // third copy; identity and undefined bytes fall through unused
         if (inField(curIdx, OFS_PL3_START, 4)) c3_q.startAddr <= shiftIn32(c3_q.startAddr, recByte);
         if (inField(curIdx, OFS_PL3_END, 4)) c3_q.endAddr <= shiftIn32(c3_q.endAddr, recByte);
         if (int'(curIdx) == OFS_PL3_FLAG) flag3_q <= recByte;
         if (inField(curIdx, OFS_PL3_MAP, MAP_BYTES)) c3_q.goodMap <= {c3_q.goodMap[119:0], recByte};
      end else begin
         done_q <= 1'b0;
      end
   end

   // ==========================================
   // record checks
   logic sigOk, flagsOk, recOk_q, loaded_q;
   assign sigOk = (headSig_q == SIG_HEAD) && (tailSig_q == SIG_TAIL);
   assign flagsOk = (flag1_q[7:1] == 7'h00) && (flag2_q[7:1] == 7'h00) && (flag3_q[7:1] == 7'h00);
   // unwritten copy must carry a zero flag; here a start of NO_PAGE_ADDR alone marks it invalid, whatever its flag
   logic c1Valid, c2Valid, c3Valid;
   assign c1Valid = flag1_q[0] && (c1_q.startAddr != NO_PAGE_ADDR);
   assign c2Valid = flag2_q[0] && (c2_q.startAddr != NO_PAGE_ADDR);
   assign c3Valid = flag3_q[0] && (c3_q.startAddr != NO_PAGE_ADDR);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         recOk_q <= 1'b0;
         loaded_q <= 1'b0;
      end else if (done_q) begin
         recOk_q <= sigOk && flagsOk;
         loaded_q <= 1'b1;
      end
   end

   assign recDone = done_q;
   assign recGood = recOk_q;
   // bitmap passed through; set bit means good
   assign copy1 = '{startAddr: c1_q.startAddr, endAddr: c1_q.endAddr, valid: c1Valid, goodMap: c1_q.goodMap};
   assign copy2 = '{startAddr: c2_q.startAddr, endAddr: c2_q.endAddr, valid: c2Valid, goodMap: c2_q.goodMap};
   assign copy3 = '{startAddr: c3_q.startAddr, endAddr: c3_q.endAddr, valid: c3Valid, goodMap: c3_q.goodMap};
   assign areas = ar_q;

   // ==========================================
   // initialisation control
   logic initDone_q, erase_q;
   logic initAllowed;
   // write-once refuses once a record exists
   assign initAllowed = !(mediaType == MEDIA_WRITE_ONCE && (initDone_q || loaded_q));
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         initDone_q <= 1'b0;
         erase_q <= 1'b0;
      end else if (initReq && initAllowed) begin
         initDone_q <= 1'b1;
         // secondary areas erased, write-once left blank
         erase_q <= (mediaType == MEDIA_RW);
      end else begin
         erase_q <= 1'b0;
      end
   end
   assign initGrant = initReq && initAllowed;
   assign initRefused = initReq && !initAllowed;
   assign eraseSecondary = erase_q;

   // ==========================================
   // defect tables
   logic [31:0] primTab [SLIP_DEPTH];
   logic [31:0] replTab [REPL_DEPTH];
   logic [15:0] primCnt_q, replCnt_q, spareOfs_q;
   logic [SLIP_DEPTH-1:0] primHit;
   logic [REPL_DEPTH-1:0] replHit;
   logic [SLIP_DEPTH-1:0] primBelow;

   for (genvar g = 0; g < SLIP_DEPTH; g++) begin : g_prim
      assign primHit[g] = (16'(g) < primCnt_q) && (primTab[g] == lateAddr);
      // defects on the far side of the target from the area count as slip
      assign primBelow[g] = (16'(g) < primCnt_q) && ((reqAddr < dmaStart) ? (primTab[g] <= reqAddr)
                            : (primTab[g] >= reqAddr));
   end
   for (genvar g = 0; g < REPL_DEPTH; g++) begin : g_repl
      assign replHit[g] = (16'(g) < replCnt_q) && (replTab[g] == reqAddr);
   end

   logic primFull, replFull, slipLimitHit, totalLimitHit;
   assign primFull = (int'(primCnt_q) >= SLIP_DEPTH);
   // skipped spares use up entries too, so the slot counter decides fullness
   assign replFull = (int'(spareOfs_q) >= REPL_DEPTH);
   // slip half of area, total whole area
   assign slipLimitHit = (32'(primCnt_q) >= 32'(DMA_SECTORS / 2));
   assign totalLimitHit = (32'(primCnt_q) + 32'(spareOfs_q) >= 32'(DMA_SECTORS));
   assign limitExceeded = slipLimitHit || totalLimitHit;
   logic lateOk;
   assign lateOk = lateAdd && !(|primHit) && !replFull && !totalLimitHit && recOk_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         primCnt_q <= 16'h0000;
      end else if (primAdd && !primFull && !slipLimitHit) begin
         primTab[primCnt_q[$clog2(SLIP_DEPTH)-1:0]] <= primAddr;
         primCnt_q <= primCnt_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         replCnt_q <= 16'h0000;
         spareOfs_q <= 16'h0000;
      end else if (spareBad) begin
         // skip a bad spare, its slot marked unused so no lookup sees an unknown
         if (!replFull) replTab[spareOfs_q[$clog2(REPL_DEPTH)-1:0]] <= NO_PAGE_ADDR;
         spareOfs_q <= spareOfs_q + 16'h0001;
      end else if (lateOk) begin
         // new entry at next spare position
         replTab[spareOfs_q[$clog2(REPL_DEPTH)-1:0]] <= lateAddr;
         replCnt_q <= spareOfs_q + 16'h0001;
         spareOfs_q <= spareOfs_q + 16'h0001;
      end
   end

   logic [31:0] lateSpare_q;
   logic [15:0] lateIndex_q;
   logic lateAcc_q, lateRej_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lateSpare_q <= 32'h00000000;
         lateIndex_q <= 16'h0000;
         lateAcc_q <= 1'b0;
         lateRej_q <= 1'b0;
      end else begin
         lateAcc_q <= lateOk && !spareBad;
         lateRej_q <= lateAdd && !lateOk && !spareBad;
         if (lateOk && !spareBad) begin
            lateSpare_q <= ar_q.ssaStart + 32'(spareOfs_q);
            lateIndex_q <= spareOfs_q;
         end
      end
   end
   assign lateAccepted = lateAcc_q;
   assign lateRejected = lateRej_q;
   assign lateSpare = lateSpare_q;
   assign lateIndex = lateIndex_q;

   // ==========================================
   // translation
   logic [15:0] slipCount;
   logic [15:0] replIdx;
   always_comb begin
      slipCount = 16'h0000;
      replIdx = 16'h0000;
      for (int i = 0; i < SLIP_DEPTH; i++) slipCount = slipCount + 16'(primBelow[i]);
      for (int i = 0; i < REPL_DEPTH; i++) if (replHit[i]) replIdx = 16'(i);
   end

   xlate_result_t rsp_q;
   logic rspValid_q;
   assign reqReady = !rspValid_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rsp_q <= '0;
         rspValid_q <= 1'b0;
      end else if (reqValid && reqReady) begin
         rspValid_q <= 1'b1;
         rsp_q.malformed <= !recOk_q;
         rsp_q.replaced <= recOk_q && (|replHit);
         rsp_q.slipped <= recOk_q && !(|replHit) && (slipCount != 16'h0000);
         if (!recOk_q) rsp_q.physical_block_address <= reqAddr;
         else if (|replHit) rsp_q.physical_block_address <= ar_q.ssaStart + 32'(replIdx);
         else if (reqAddr < dmaStart || !dmaStartValid) rsp_q.physical_block_address <= reqAddr + 32'(slipCount);
         else rsp_q.physical_block_address <= reqAddr - 32'(slipCount);
      end else begin
         rspValid_q <= 1'b0;
      end
   end
   assign rspValid = rspValid_q;
   assign rsp = rsp_q;

   // ==========================================
   // checks
   AST_MALFORMED_SIG: assert property (@(posedge core_clk) disable iff (sys_rst)
      done_q && !sigOk |=> !recOk_q) else $error("bad signature accepted");
   AST_FLAG_ILLEGAL: assert property (@(posedge core_clk) disable iff (sys_rst)
      done_q && !flagsOk |=> !recOk_q) else $error("illegal flag accepted");
   AST_START_INVALID: assert property (@(posedge core_clk) disable iff (sys_rst)
      c1_q.startAddr == NO_PAGE_ADDR |-> !copy1.valid) else $error("unwritten copy valid");
   AST_INIT_ONCE: assert property (@(posedge core_clk) disable iff (sys_rst)
      mediaType == MEDIA_WRITE_ONCE && initDone_q && initReq |-> initRefused && !initGrant)
      else $error("write-once reinitialised");
   AST_ERASE_RW: assert property (@(posedge core_clk) disable iff (sys_rst)
      initGrant && mediaType == MEDIA_RW |=> eraseSecondary) else $error("no erase after init");
   AST_NO_DUP: assert property (@(posedge core_clk) disable iff (sys_rst)
      lateAdd && (|primHit) && !spareBad |=> lateRejected && !lateAccepted) else $error("primary addr taken");
   AST_SPARE_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
      lateAccepted |-> lateSpare == ar_q.ssaStart + 32'(lateIndex)) else $error("spare address wrong");
   AST_SKIP_SPARE: assert property (@(posedge core_clk) disable iff (sys_rst)
      spareBad |=> spareOfs_q == $past(spareOfs_q) + 16'h0001) else $error("bad spare not skipped");
   AST_RSP_ERR: assert property (@(posedge core_clk) disable iff (sys_rst)
      reqValid && reqReady && !recOk_q |=> rspValid && rsp.malformed) else $error("missing error result");
   AST_SLIP_LIMIT: assert property (@(posedge core_clk) disable iff (sys_rst)
      32'(primCnt_q) <= 32'(DMA_SECTORS / 2)) else $error("slip limit exceeded");
endmodule : defect_map_translator

// ==== medium_model.sv ====
// medium model: plays back one recorded definition sector, byte by byte
// assumes the bench fills img before calling play; one drive clock
`timescale 1ns/1ps
module medium_model (
   // clock
   input wire logic core_clk,
   // record byte stream toward the translator
   output logic recValid,
   output logic [7:0] recByte,
   output logic recFirst
);
   import defect_map_pkg::*;
   logic [7:0] img [0:SECTOR_BYTES-1];

   initial begin
      recValid = 1'b0;
      recFirst = 1'b0;
      recByte = 8'h00;
   end

   // ==========================================
   // playback
   task automatic play();
      for (int i = 0; i < SECTOR_BYTES; i++) begin
         @(posedge core_clk);
         #1;
         recValid = 1'b1;
         recFirst = (i == 0);
         recByte = img[i];
      end
      @(posedge core_clk);
      #1;
      recValid = 1'b0;
      recFirst = 1'b0;
      // idle line never shows the last byte again
      recByte = ~recByte;
   endtask : play
endmodule : medium_model

// ==== tb_top.sv ====
// testbench for the defect map translator
// assumes the medium model streams records; all other inputs driven here
`timescale 1ns/1ps
module tb_top;
   import defect_map_pkg::*;
   logic core_clk, sys_rst, recValid, recFirst, recDone, recGood;
   logic [7:0] recByte;
   list_copy_t copy1, copy2, copy3;
   area_map_t areas;
   media_t mediaType;
   logic initReq, initGrant, initRefused, eraseSecondary, dmaStartValid, primAdd, lateAdd, spareBad;
   logic lateAccepted, lateRejected, reqValid, reqReady, rspValid, limitExceeded;
   logic [31:0] dmaStart, primAddr, lateAddr, lateSpare, reqAddr;
   logic [15:0] lateIndex;
   xlate_result_t rsp, r;
   int num_errors = 0;
   int checks_done = 0;

   medium_model u_medium_model (.core_clk(core_clk), .recValid(recValid), .recByte(recByte), .recFirst(recFirst));
   defect_map_translator u_defect_map_translator (
      .core_clk(core_clk), .sys_rst(sys_rst), .recValid(recValid), .recByte(recByte), .recFirst(recFirst),
      .recDone(recDone), .recGood(recGood), .copy1(copy1), .copy2(copy2), .copy3(copy3), .areas(areas),
      .mediaType(mediaType), .initReq(initReq), .initGrant(initGrant), .initRefused(initRefused),
      .eraseSecondary(eraseSecondary), .dmaStartValid(dmaStartValid), .dmaStart(dmaStart),
      .primAdd(primAdd), .primAddr(primAddr), .lateAdd(lateAdd), .lateAddr(lateAddr), .spareBad(spareBad),
      .lateAccepted(lateAccepted), .lateRejected(lateRejected), .lateSpare(lateSpare), .lateIndex(lateIndex),
      .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr), .rspValid(rspValid), .rsp(rsp),
      .limitExceeded(limitExceeded));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [287:0] seen, input logic [287:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task automatic put(input int ofs, input int n, input logic [31:0] v);
      for (int i = 0; i < n; i++) u_medium_model.img[ofs+i] = v[8*(n-1-i) +: 8];
   endtask : put

   task automatic load(input logic [7:0] flag1, input logic [15:0] tail, output logic good);
      put(OFS_PL1_FLAG, 1, {24'h0, flag1});
      put(OFS_SIG_TAIL, 2, {16'h0, tail});
      u_medium_model.play();
      chk("recDone", recDone, 1'b1);
      repeat (3) @(posedge core_clk);
      #1;
      good = recGood;
   endtask : load

   task automatic xlate(input logic [31:0] a, output xlate_result_t res);
      @(posedge core_clk);
      #1;
      reqValid = 1'b1;
      reqAddr = a;
      // ready is a register output, settled between edges; wait for it, then let one edge take the request
      for (int i = 0; i < 8 && reqReady !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1;
      reqValid = 1'b0;
      res = rsp;
      chk("rspValid", rspValid, 1'b1);
   endtask : xlate

   task automatic late(input logic [31:0] a, input logic acc, input logic [31:0] spare, input logic [15:0] idx);
      @(posedge core_clk);
      #1;
      lateAdd = 1'b1;
      lateAddr = a;
      @(posedge core_clk);
      #1;
      lateAdd = 1'b0;
      chk("lateAccepted", {lateAccepted, lateRejected}, {acc, ~acc});
      if (acc) chk("lateSpare", {lateSpare, lateIndex}, {spare, idx});
   endtask : late

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      #5_000_000;
      num_errors++;
      conclude();
   end

   // ==========================================
   // tests
   initial begin
      logic g;
      sys_rst = 1'b1;
      mediaType = MEDIA_RW;
      {initReq, dmaStartValid, primAdd, lateAdd, spareBad, reqValid} = '0;
      {dmaStart, primAddr, lateAddr, reqAddr} = '0;
      // vendor, revision and unspecified bytes carry junk the parser must skip
      for (int i = 0; i < SECTOR_BYTES; i++) u_medium_model.img[i] = (i < 35) ? 8'hee : 8'h33;
      put(OFS_SIG_HEAD, 2, 32'ha5a5);
      put(OFS_PL1_START, 4, 32'h00001234);
      put(OFS_PL1_END, 4, 32'h00001240);
      put(OFS_PL1_MAP, 4, 32'hf0000000);
      put(OFS_SL_START, 4, 32'h00000020);
      put(OFS_SL_END, 4, 32'h00000027);
      put(OFS_SL_MAXENT, 2, 32'h03e8);
      put(OFS_PSA_START, 4, 32'h00000030);
      put(OFS_PSA_END, 4, 32'h00000038);
      put(OFS_SSA_START, 4, 32'h00000100);
      put(OFS_SSA_END, 4, 32'h000001ff);
      put(OFS_COPY_START, 4, 32'h00000200);
      put(OFS_COPY_END, 4, 32'h00000207);
      put(OFS_PL2_START, 4, 32'h00002000);
      put(OFS_PL2_END, 4, 32'h00002004);
      put(OFS_PL2_FLAG, 1, 32'h01);
      put(OFS_PL3_START, 4, NO_PAGE_ADDR);
      put(OFS_PL3_END, 4, 32'h0);
      put(OFS_PL3_FLAG, 1, 32'h00);
      repeat (5) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      chk("reqReady", reqReady, 1'b1);
      load(8'h01, 16'h5a5a, g);
      chk("recGood", g, 1'b1);
      chk("copy1", copy1, {32'h1234, 32'h1240, 1'b1, 32'hf0000000, {12{8'h33}}});
      chk("areas", areas, {32'h20, 32'h27, 16'h03e8, 32'h30, 32'h38, 32'h100, 32'h1ff, 32'h200, 32'h207});
      chk("copy2", {copy2.startAddr, copy2.valid}, {32'h2000, 1'b1});
      chk("copy3", copy3[192:128], {NO_PAGE_ADDR, 32'h0, 1'b0});
      // slipping around an area starting at 1000
      @(posedge core_clk);
      #1;
      dmaStartValid = 1'b1;
      dmaStart = 32'd1000;
      for (int k = 0; k < 3; k++) begin
         primAdd = 1'b1;
         primAddr = (k == 0) ? 32'd10 : (k == 1) ? 32'd20 : 32'd1500;
         @(posedge core_clk);
         #1;
      end
      primAdd = 1'b0;
      // defects only beyond the target, on the area side, leave it in place
      xlate(32'd5, r);
      chk("slip low", r, {32'd5, 3'b000});
      xlate(32'd15, r);
      chk("slip mid", r, {32'd16, 3'b010});
      xlate(32'd1400, r);
      chk("slip high", r, {32'd1399, 3'b010});
      // linear replacement into the secondary spares
      late(32'd50, 1'b1, 32'h100, 16'd0);
      @(posedge core_clk);
      #1;
      spareBad = 1'b1;
      @(posedge core_clk);
      #1;
      spareBad = 1'b0;
      late(32'd60, 1'b1, 32'h102, 16'd2);
      late(32'd20, 1'b0, 32'h0, 16'h0);
      late(32'h102, 1'b1, 32'h103, 16'd3);
      xlate(32'd60, r);
      chk("replaced", r, {32'h102, 3'b001});
      chk("limitExceeded", limitExceeded, 1'b0);
      // initialisation
      @(posedge core_clk);
      #1;
      initReq = 1'b1;
      #1;
      chk("rw grant", {initGrant, initRefused}, 2'b10);
      @(posedge core_clk);
      #1;
      initReq = 1'b0;
      chk("eraseSecondary", eraseSecondary, 1'b1);
      mediaType = MEDIA_WRITE_ONCE;
      @(posedge core_clk);
      #1;
      initReq = 1'b1;
      #1;
      chk("wo refuse", {initGrant, initRefused}, 2'b01);
      @(posedge core_clk);
      #1;
      initReq = 1'b0;
      // malformed records
      load(8'h01, 16'h5a5b, g);
      chk("bad tail", g, 1'b0);
      xlate(32'd50, r);
      chk("malformed", r[34:2], {32'd50, 1'b1});
      load(8'h02, 16'h5a5a, g);
      chk("bad flag", g, 1'b0);
      conclude();
   end
endmodule : tb_top
